/* lsb_cfg.svh */
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 8-bit registers, 40 MHz system clock
// Notes: Included by the load-switch and buck register slice
`ifndef LSB_CFG_SVH
`define LSB_CFG_SVH

// ***************************************************
// Register offsets
// ***************************************************
`define LSB_UNLOCK_OFF 8'h10
`define LSB_CFG_OFF 8'h15
`define LSB_BUCK1_OFF 8'h16
`define LSB_BUCK2_OFF 8'h17

// ***************************************************
// Reset values
// ***************************************************
`define LSB_CFG_RST 8'h00
`define LSB_BUCK_RST 8'h99

// ***************************************************
// Field positions
// ***************************************************
`define LSB_PF_OFF_LSB 3
`define LSB_DIS_LSB 0
`define LSB_CFG_USED_MSB 5
`define LSB_PFM_BIT 7
`define LSB_RSVD_BIT 6
`define LSB_CODE_MSB 5

// ***************************************************
// Timing
// ***************************************************
`define LSB_CLK_HZ 40000000
`define LSB_BLANK_MS 5
`define LSB_BLANK_CYC ((`LSB_BLANK_MS * `LSB_CLK_HZ) / 1000)

`endif

/* lsb_pkg.sv */
// Purpose: Types shared by the load-switch and buck register slice
// Assumes: lsb_cfg.svh holds the numbers
// Notes: None
package lsb_pkg;

   // Register access request from the serial interface engine
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] data;
   } lsb_bus_type;

   // Applied converter setting
   typedef struct packed {
      logic pulseSkip;
      logic [5:0] code;
   } lsb_buck_type;

endpackage : lsb_pkg

/* lsb_blank_timer.sv */
// Purpose: Retriggerable monitor blanking window
// Assumes: start is a one-cycle pulse
// Notes: A start during a window restarts the full count
`timescale 1ns/1ps
module lsb_blank_timer #(
   parameter int CYCLES = 200000
) (
   input wire logic sys_clk, // System clock
   input wire logic rst, // Synchronous reset
   input wire logic start, // Restart window
   output logic busy // Window active
);
   localparam int W = $clog2(CYCLES + 1);
   localparam logic [W-1:0] LOAD = W'(CYCLES);

   logic [W-1:0] count_q;
   logic busy_q;
   logic lastTick;

   assign lastTick = (count_q == W'(1));
   assign busy = busy_q;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         count_q <= '0;
         busy_q <= 1'b0;
      end else if (start) begin
         count_q <= LOAD;
         busy_q <= 1'b1;
      end else if (busy_q) begin
         count_q <= count_q - W'(1);
         busy_q <= !lastTick;
      end
   end

   a_blank_len: assert property (@(posedge sys_clk) disable iff (rst)
      start |=> busy [*8])
      else $error("Blank window ended early");

endmodule : lsb_blank_timer

/* lsb_regs.sv */
// Purpose: Load-switch configuration and two buck control registers
// Assumes: Serial engine delivers decoded one-cycle read/write strobes
// Notes: Unlock arming is decoded here; commit and analog parts live outside this block
//
// Operation
// - Switch config register at 0x15, resets to zero, password protected.
// - Bit 5 set: switch three off while power-fail output is low.
// - Bit 4 set: switch two off while power-fail output is low.
// - Bit 3 set: switch one off while power-fail output is low.
// - Bit 2 set: switch three output discharged while it is off.
// - Bit 1 set: switch two output discharged while it is off.
// - Bit 0 set: switch one output discharged while it is off.
// - Buck one register at 0x16, resets to 0x99, password protected.
// - Any buck one write blanks its voltage monitoring for 5 ms.
// - Buck one voltage applies only after commit bit in 0x1A.
// - Buck one bit 7 enables pulse skip; bit 6 reads zero.
// - Buck one bits 5-0 pick voltage, 0.850 V to 1.675 V.
// - Buck two register at 0x17, resets to 0x99, password protected.
// - Any buck two write blanks its voltage monitoring for 5 ms.
// - Buck two voltage applies only after commit bit in 0x1A.
// - Buck two bit 7 enables pulse skip; bit 6 reads zero.
// - Buck two bits 5-0 use the same voltage table.
`timescale 1ns/1ps
`include "lsb_cfg.svh"
module lsb_regs #(
   parameter int BLANK_CYCLES = `LSB_BLANK_CYC
) (
   input wire logic sys_clk, // System clock
   input wire logic rst, // Synchronous reset
   input wire lsb_pkg::lsb_bus_type busIn, // Register access strobes
   input wire logic commitGo, // Commit bit written
   input wire logic commitWithDisable, // Commit-with-disable bit written
   input wire logic powerFailOutN, // Power-fail comparator, low = tripped
   input wire logic [2:0] swEnable, // Switch enables from sequencer
   output logic [7:0] rdData, // Read data
   output logic rdValid, // Read data valid pulse
   output logic [2:0] swOn, // Switch gate drive
   output logic [2:0] swDischarge, // Output discharge enable
   output lsb_pkg::lsb_buck_type buckOne, // Applied buck one setting
   output lsb_pkg::lsb_buck_type buckTwo, // Applied buck two setting
   output logic [1:0] monitorBlank // Voltage monitor blanking
);
   import lsb_pkg::*;

   // ***************************************************
   // Decode
   // ***************************************************
   logic [7:0] cfg_q;
   logic [7:0] buck_q [2];
   logic [5:0] target_q [2];
   logic [1:0] pfmApplied_q;
   logic armed_q;
   logic [7:0] rdData_q;
   logic rdValid_q;
   logic [2:0] swOn_q;
   logic [2:0] swDis_q;

   wire hitUnlock = (busIn.addr == `LSB_UNLOCK_OFF);
   wire hitCfg = (busIn.addr == `LSB_CFG_OFF);
   wire hitBuck1 = (busIn.addr == `LSB_BUCK1_OFF);
   wire hitBuck2 = (busIn.addr == `LSB_BUCK2_OFF);
   wire protWr = busIn.wr && armed_q;
   wire wrCfg = protWr && hitCfg;
   wire [1:0] wrBuck = {protWr && hitBuck2, protWr && hitBuck1};
   wire commit = commitGo || commitWithDisable;
   wire [2:0] pfOff = cfg_q[`LSB_PF_OFF_LSB +: 3];
   wire [2:0] disEn = cfg_q[`LSB_DIS_LSB +: 3];
   wire [7:0] cfgRead = {2'h0, cfg_q[`LSB_CFG_USED_MSB:0]};
   wire [7:0] rdMux = hitCfg ? cfgRead :
                      hitBuck1 ? buck_q[0] :
                      hitBuck2 ? buck_q[1] : 8'h00;

   // ***************************************************
   // Password arming
   // ***************************************************
   // Any write consumes the arm, so only the very next write is accepted
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         armed_q <= 1'b0;
      end else if (busIn.wr) begin
         armed_q <= hitUnlock;
      end
   end

   // ***************************************************
   // Load-switch configuration
   // ***************************************************
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cfg_q <= `LSB_CFG_RST;
      end else if (wrCfg) begin
         cfg_q <= {2'h0, busIn.data[`LSB_CFG_USED_MSB:0]};
      end
   end

   // ***************************************************
   // Switch control
   // ***************************************************
   for (genvar i = 0; i < 3; i++) begin : g_sw
      wire swOnD = swEnable[i] && !(pfOff[i] && !powerFailOutN);
      always_ff @(posedge sys_clk) begin
         if (rst) begin
            swOn_q[i] <= 1'b0;
            swDis_q[i] <= 1'b0;
         end else begin
            swOn_q[i] <= swOnD;
            swDis_q[i] <= disEn[i] && !swOnD;
         end
      end
   end

   assign swOn = swOn_q;
   assign swDischarge = swDis_q;

   // ***************************************************
   // Buck control registers
   // ***************************************************
   for (genvar c = 0; c < 2; c++) begin : g_buck
      always_ff @(posedge sys_clk) begin
         if (rst) begin
            buck_q[c] <= `LSB_BUCK_RST;
            target_q[c] <= 6'(`LSB_BUCK_RST & 8'h3f);
            pfmApplied_q[c] <= 1'b1;
         end else begin
            if (wrBuck[c]) begin
               // Reserved bit forced low
               buck_q[c] <= busIn.data & 8'hbf;
            end
            pfmApplied_q[c] <= buck_q[c][`LSB_PFM_BIT];
            if (commit) begin
               target_q[c] <= buck_q[c][`LSB_CODE_MSB:0];
            end
         end
      end

      lsb_blank_timer #(
         .CYCLES(BLANK_CYCLES)
      ) u_blank (
         .sys_clk(sys_clk),
         .rst(rst),
         .start(wrBuck[c]),
         .busy(monitorBlank[c])
      );
   end

   // Codes map 0.850 V + 10 mV steps to 0x32, then 25 mV steps to 0x3f
   assign buckOne = '{pulseSkip: pfmApplied_q[0], code: target_q[0]};
   assign buckTwo = '{pulseSkip: pfmApplied_q[1], code: target_q[1]};

   // ***************************************************
   // Read path
   // ***************************************************
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rdData_q <= 8'h00;
         rdValid_q <= 1'b0;
      end else begin
         rdValid_q <= busIn.rd;
         if (busIn.rd) begin
            rdData_q <= rdMux;
         end
      end
   end

   assign rdData = rdData_q;
   assign rdValid = rdValid_q;

   // ***************************************************
   // Checks
   // ***************************************************
   a_cfg_reset: assert property (@(posedge sys_clk)
      rst |=> (cfg_q == 8'h00))
      else $error("Config reset value wrong");

   a_sw3_powerfail: assert property (@(posedge sys_clk) disable iff (rst)
      (cfg_q[5] && !powerFailOutN) |=> !swOn[2])
      else $error("Switch three on during power fail");

   a_sw2_powerfail: assert property (@(posedge sys_clk) disable iff (rst)
      (cfg_q[4] && !powerFailOutN) |=> !swOn[1])
      else $error("Switch two on during power fail");

   a_sw1_powerfail: assert property (@(posedge sys_clk) disable iff (rst)
      (!cfg_q[3] && swEnable[0]) |=> swOn[0])
      else $error("Switch one cut without power-fail option");

   a_sw3_discharge: assert property (@(posedge sys_clk) disable iff (rst)
      (cfg_q[2] && !swEnable[2]) |=> swDischarge[2])
      else $error("Switch three not discharged");

   a_sw2_discharge: assert property (@(posedge sys_clk) disable iff (rst)
      swDischarge[1] |-> !swOn[1])
      else $error("Switch two discharged while on");

   a_sw1_discharge: assert property (@(posedge sys_clk) disable iff (rst)
      !cfg_q[0] |=> !swDischarge[0])
      else $error("Switch one discharged when disabled");

   a_buck_reset: assert property (@(posedge sys_clk)
      rst |=> (buck_q[0] == 8'h99) && (buck_q[1] == 8'h99))
      else $error("Buck reset value wrong");

   a_blank_one: assert property (@(posedge sys_clk) disable iff (rst)
      wrBuck[0] |=> monitorBlank[0] [*4])
      else $error("Buck one monitor not blanked");

   a_hold_target: assert property (@(posedge sys_clk) disable iff (rst)
      !commit |=> $stable(buckOne.code) && $stable(buckTwo.code))
      else $error("Voltage changed without commit");

   a_reserved_read: assert property (@(posedge sys_clk) disable iff (rst)
      rdValid |-> !rdData[6])
      else $error("Reserved bit read as one");

   a_locked_write: assert property (@(posedge sys_clk) disable iff (rst)
      (busIn.wr && !armed_q) |=> $stable(cfg_q) && $stable(buck_q[0]) && $stable(buck_q[1]))
      else $error("Locked write took effect");

   a_sw1_pf_off: assert property (@(posedge sys_clk) disable iff (rst)
      (cfg_q[3] && !powerFailOutN) |=> !swOn[0])
      else $error("Switch one on during power fail");

   a_sw3_pf_keep: assert property (@(posedge sys_clk) disable iff (rst)
      (!cfg_q[5] && swEnable[2]) |=> swOn[2])
      else $error("Switch three cut without power-fail option");

   a_sw2_pf_keep: assert property (@(posedge sys_clk) disable iff (rst)
      (!cfg_q[4] && swEnable[1]) |=> swOn[1])
      else $error("Switch two cut without power-fail option");

   a_sw2_dis_on: assert property (@(posedge sys_clk) disable iff (rst)
      (cfg_q[1] && !swEnable[1]) |=> swDischarge[1])
      else $error("Switch two not discharged");

   a_sw1_dis_on: assert property (@(posedge sys_clk) disable iff (rst)
      (cfg_q[0] && !swEnable[0]) |=> swDischarge[0])
      else $error("Switch one not discharged");

   a_sw3_dis_off: assert property (@(posedge sys_clk) disable iff (rst)
      !cfg_q[2] |=> !swDischarge[2])
      else $error("Switch three discharged when disabled");

   a_sw2_dis_off: assert property (@(posedge sys_clk) disable iff (rst)
      !cfg_q[1] |=> !swDischarge[1])
      else $error("Switch two discharged when disabled");

   a_sw1_dis_safe: assert property (@(posedge sys_clk) disable iff (rst)
      swDischarge[0] |-> !swOn[0])
      else $error("Switch one discharged while on");

   a_cfg_rsvd: assert property (@(posedge sys_clk) disable iff (rst)
      cfg_q[7:6] == 2'h0)
      else $error("Config reserved bits set");

   a_buck_rsvd: assert property (@(posedge sys_clk) disable iff (rst)
      !buck_q[0][`LSB_RSVD_BIT] && !buck_q[1][`LSB_RSVD_BIT])
      else $error("Buck reserved bit set");

   a_blank_two: assert property (@(posedge sys_clk) disable iff (rst)
      wrBuck[1] |=> monitorBlank[1] [*4])
      else $error("Buck two monitor not blanked");

   a_commit_one: assert property (@(posedge sys_clk) disable iff (rst)
      commit |=> (buckOne.code == $past(buck_q[0][5:0])))
      else $error("Buck one commit did not apply code");

   a_commit_two: assert property (@(posedge sys_clk) disable iff (rst)
      commit |=> (buckTwo.code == $past(buck_q[1][5:0])))
      else $error("Buck two commit did not apply code");

   a_skip_one: assert property (@(posedge sys_clk) disable iff (rst)
      buckOne.pulseSkip == $past(buck_q[0][7]))
      else $error("Buck one pulse skip not following register");

   a_skip_two: assert property (@(posedge sys_clk) disable iff (rst)
      buckTwo.pulseSkip == $past(buck_q[1][7]))
      else $error("Buck two pulse skip not following register");

   a_read_answer: assert property (@(posedge sys_clk) disable iff (rst)
      busIn.rd |=> rdValid)
      else $error("Read not answered");

   a_read_cfg: assert property (@(posedge sys_clk) disable iff (rst)
      (busIn.rd && hitCfg) |=> (rdData == {2'h0, $past(cfg_q[5:0])}))
      else $error("Config read data wrong");

   a_read_buck_one: assert property (@(posedge sys_clk) disable iff (rst)
      (busIn.rd && hitBuck1) |=> (rdData == $past(buck_q[0])))
      else $error("Buck one read data wrong");

   a_read_buck_two: assert property (@(posedge sys_clk) disable iff (rst)
      (busIn.rd && hitBuck2) |=> (rdData == $past(buck_q[1])))
      else $error("Buck two read data wrong");

   a_unlock_arm: assert property (@(posedge sys_clk) disable iff (rst)
      (busIn.wr && hitUnlock) |=> armed_q)
      else $error("Unlock write did not arm");

   a_arm_consumed: assert property (@(posedge sys_clk) disable iff (rst)
      (busIn.wr && !hitUnlock) |=> !armed_q)
      else $error("Arm not consumed by write");

   a_write_buck: assert property (@(posedge sys_clk) disable iff (rst)
      wrBuck[0] |=> (buck_q[0] == ($past(busIn.data) & 8'hbf)))
      else $error("Buck one write not stored");

endmodule : lsb_regs

/* lsb_host_model.sv */
// Purpose: Host processor model driving the register access strobes
// Assumes: Strobes change on the falling clock edge, one cycle wide
// Notes: Released address and data lines show inverted values
`timescale 1ns/1ps
`include "lsb_cfg.svh"
module lsb_host_model (
   input wire logic sys_clk, // System clock
   input wire logic [7:0] rdData, // Read data
   input wire logic rdValid, // Read data valid
   output lsb_pkg::lsb_bus_type busIn, // Register access strobes
   output logic commitGo, // Commit pulse
   output logic commitWithDisable // Commit-with-disable pulse
);
   import lsb_pkg::*;
   initial begin
      busIn = '0;
      commitGo = 1'b0;
      commitWithDisable = 1'b0;
   end
   task automatic wrReg(input logic [7:0] addr, input logic [7:0] data);
      @(negedge sys_clk);
      busIn = '{wr: 1'b1, rd: 1'b0, addr: addr, data: data};
      @(negedge sys_clk);
      busIn = '{wr: 1'b0, rd: 1'b0, addr: ~addr, data: ~data};
   endtask : wrReg
   task automatic unlockWrite(input logic [7:0] addr, input logic [7:0] data);
      wrReg(`LSB_UNLOCK_OFF, ~data);
      wrReg(addr, data);
   endtask : unlockWrite
   task automatic rdReg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
      @(negedge sys_clk);
      busIn = '{wr: 1'b0, rd: 1'b1, addr: addr, data: 8'h5a};
      @(negedge sys_clk);
      data = rdData;
      ok = rdValid;
      busIn = '{wr: 1'b0, rd: 1'b0, addr: ~addr, data: 8'ha5};
   endtask : rdReg
   task automatic commit(input logic withDisable);
      @(negedge sys_clk);
      commitGo = ~withDisable;
      commitWithDisable = withDisable;
      @(negedge sys_clk);
      commitGo = 1'b0;
      commitWithDisable = 1'b0;
   endtask : commit
endmodule : lsb_host_model

/* tb_lsb_regs.sv */
// Purpose: Self-checking bench for the switch and buck register slice
// Assumes: Short blanking count, inputs driven on the falling edge
// Notes: Reference model held in plain arrays
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samplesChecked++; if ((g) !== (e)) begin mismatches++; \
   $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_lsb_regs;
   import lsb_pkg::*;
   localparam int BLANK = 20;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic powerFailOutN = 1'b1;
   logic [2:0] swEnable = 3'h0;
   lsb_bus_type busIn;
   logic commitGo, commitWithDisable, rdValid, gotV;
   logic [7:0] rdData, got;
   logic [2:0] swOn, swDischarge, expOn;
   lsb_buck_type buckOne, buckTwo;
   logic [1:0] monitorBlank;
   logic [7:0] mReg [3];
   logic [5:0] mCode [2];
   logic [5:0] codeList [4] = '{6'h00, 6'h32, 6'h33, 6'h3f};
   int mismatches = 0;
   int samplesChecked = 0;
   int cycles = 0;
   lsb_regs #(.BLANK_CYCLES(BLANK)) i_lsb_regs (.sys_clk(sys_clk), .rst(rst), .busIn(busIn),
      .commitGo(commitGo), .commitWithDisable(commitWithDisable),
      .powerFailOutN(powerFailOutN), .swEnable(swEnable), .rdData(rdData), .rdValid(rdValid),
      .swOn(swOn), .swDischarge(swDischarge), .buckOne(buckOne), .buckTwo(buckTwo),
      .monitorBlank(monitorBlank));
   lsb_host_model i_lsb_host_model (.sys_clk(sys_clk), .rdData(rdData), .rdValid(rdValid),
      .busIn(busIn), .commitGo(commitGo), .commitWithDisable(commitWithDisable));
   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      if (mismatches == 0 && samplesChecked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : print_verdict
   task automatic modelReset();
      mReg = '{8'h00, 8'h99, 8'h99};
      mCode = '{6'h19, 6'h19};
   endtask : modelReset
   // Accepted write: update model with read-only bits cleared
   task automatic putReg(input int i, input logic [7:0] v);
      i_lsb_host_model.unlockWrite(8'h15 + i[7:0], v);
      mReg[i] = v & ((i == 0) ? 8'h3f : 8'hbf);
   endtask : putReg
   task automatic checkAll();
      for (int i = 0; i < 4; i++) begin
         i_lsb_host_model.rdReg(8'h15 + i[7:0], got, gotV);
         `CHK("rdValid", 1'b1, gotV)
         `CHK("rdData", ((i < 3) ? mReg[i] : 8'h00), got)
      end
      `CHK("buckOne", {mReg[1][7], mCode[0]}, buckOne)
      `CHK("buckTwo", {mReg[2][7], mCode[1]}, buckTwo)
   endtask : checkAll
   initial begin
      repeat (5) @(negedge sys_clk);
      rst = 1'b0;
      void'($urandom(32'h88a8cc51));
      modelReset();
      checkAll();
      // ***************************************************
      // Protected writes, refused then accepted
      // ***************************************************
      for (int k = 0; k < 6; k++) begin
         if (k < 3) i_lsb_host_model.wrReg(8'h15 + k[7:0], ~mReg[k]);
         else putReg(k - 3, 8'($urandom));
         @(negedge sys_clk);
         if (k > 3) `CHK("monitorBlank", 1'b1, monitorBlank[k - 4])
         checkAll();
      end
      i_lsb_host_model.wrReg(8'h10, 8'h00);
      i_lsb_host_model.wrReg(8'h20, 8'h00);
      i_lsb_host_model.wrReg(8'h16, ~mReg[1]);
      checkAll();
      // ***************************************************
      // Pending codes and both commit kinds
      // ***************************************************
      for (int j = 0; j < 4; j++) begin
         putReg(1, {1'($urandom), 1'b1, codeList[j]});
         putReg(2, {1'($urandom), 1'b0, ~codeList[j]});
         checkAll();
         i_lsb_host_model.commit(j[0]);
         @(negedge sys_clk);
         mCode = '{mReg[1][5:0], mReg[2][5:0]};
         checkAll();
      end
      // ***************************************************
      // Blanking window length and restart
      // ***************************************************
      repeat (BLANK + 2) @(negedge sys_clk);
      putReg(2, 8'($urandom));
      @(negedge sys_clk);
      `CHK("monitorBlank", 2'b10, monitorBlank)
      repeat (BLANK - 8) @(negedge sys_clk);
      `CHK("monitorBlank", 2'b10, monitorBlank)
      putReg(2, 8'($urandom));
      repeat (BLANK - 1) @(negedge sys_clk);
      `CHK("monitorBlank", 2'b10, monitorBlank)
      repeat (1) @(negedge sys_clk);
      `CHK("monitorBlank", 2'b00, monitorBlank)
      // ***************************************************
      // Power-fail switch off and discharge
      // ***************************************************
      for (int n = 0; n < 48; n++) begin
         if (n % 8 == 0) putReg(0, 8'($urandom));
         @(negedge sys_clk);
         powerFailOutN = 1'($urandom);
         swEnable = 3'($urandom);
         repeat (2) @(negedge sys_clk);
         expOn = swEnable & ~(mReg[0][5:3] & {3{~powerFailOutN}});
         `CHK("swOn", expOn, swOn)
         `CHK("swDischarge", mReg[0][2:0] & ~expOn, swDischarge)
      end
      rst = 1'b1;
      repeat (2) @(negedge sys_clk);
      rst = 1'b0;
      modelReset();
      checkAll();
      print_verdict();
   end
endmodule : tb_lsb_regs
